// ===== rtl/path_sm_pkg.sv
`default_nettype none
package path_sm_pkg;
  localparam int LANES = 8;
  // State register encodings written on every lane
  localparam logic [3:0] CODE_GROUND      = 4'h1;
  localparam logic [3:0] CODE_OPERATIONAL = 4'h4;
  localparam logic [3:0] CODE_INITIALIZING = 4'h7;
  localparam logic [3:0] CODE_TEARDOWN    = 4'h3;
  localparam logic [3:0] CODE_READY_IDLE  = 4'h2;
  localparam logic [3:0] CODE_UNMUTING    = 4'h5;
  localparam logic [3:0] CODE_MUTING      = 4'h6;
  // Register offsets
  localparam logic [3:0] ADDR_CONTROL   = 4'h0;
  localparam logic [3:0] ADDR_OFF       = 4'h1;
  localparam logic [3:0] ADDR_MUTE      = 4'h2;
  localparam logic [3:0] ADDR_STATE     = 4'h3;
  localparam logic [3:0] ADDR_FLAGS     = 4'h4;
  localparam logic [3:0] ADDR_PENDING   = 4'h5;
  localparam logic [3:0] ADDR_DURATION  = 4'h6;
  // Field positions and reset values
  localparam int CTRL_TEARDOWN_BIT = 0;
  localparam int CTRL_CLR_FLAGS_BIT = 1;
  localparam int DUR_INIT_BIT  = 0;
  localparam int DUR_OTHER_BIT = 1;
  localparam logic [7:0] PENDING_RESET = 8'hFF;
  localparam logic [1:0] DURATION_RESET = 2'h3;
  localparam logic [31:0] TEARDOWN_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    path_ground_state,
    path_initializing_state,
    path_ready_idle_state,
    path_teardown_state,
    tx_unmuting_state,
    path_operational_state,
    tx_muting_state
  } path_state_type;

  // Hardware progress signals from the data path electronics
  typedef struct packed {
    logic init_done;
    logic teardown_done;
    logic tx_stable;
    logic tx_quiet;
  } progress_type;

  // Power and output controls towards the data path electronics
  typedef struct packed {
    logic       power_on;
    logic       configure;
    logic       adapt_auto;
    logic [7:0] tx_quiescent;
  } drive_type;

  // Code reported in the per-lane state register
  function automatic logic [3:0] state_code(input path_state_type s);
    unique case (s)
      path_ground_state:       state_code = CODE_GROUND;
      path_initializing_state: state_code = CODE_INITIALIZING;
      path_ready_idle_state:   state_code = CODE_READY_IDLE;
      path_teardown_state:     state_code = CODE_TEARDOWN;
      tx_unmuting_state:       state_code = CODE_UNMUTING;
      path_operational_state:  state_code = CODE_OPERATIONAL;
      tx_muting_state:         state_code = CODE_MUTING;
      default:                 state_code = CODE_GROUND;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== rtl/data_path_state_machine.sv
// How it works
// - Initializing powers and configures the path
// - Initializing clears every lane's pending bit
// - Initializing holds all Tx outputs quiescent
// - Adaptation completes automatically when signal appears
// - Output controls ignored while initializing
// - Teardown request during init goes teardown
// - Init finishes only when resources ready
// - Entry writes state; steady entry evaluates flag
// - Ready idle: lanes follow off/mute controls
// - Re-teardown in ready idle has priority
// - No mute request: ready idle goes unmuting
// - Teardown may power down unshared electronics
// - Teardown quiets outputs, controls ignored
// - Teardown done goes to ground state
// - Unmuting unmutes all lanes of path except auto-squelch
// - Mute request during unmuting goes muting
// - Unmuting ends when Tx outputs stable
// - Operational keeps outputs unmuted except auto-squelch
// - Mute request in operational goes muting
// - Auto-squelch may mute lane on loss
// - Any lane off or mute requests muting
// - Flag only after significant transient state
// - State changes never clear flags
`default_nettype none
module data_path_state_machine
  import path_sm_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Register port
  input  wire logic [3:0]   addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [31:0]  rdata,
  // Data path electronics
  input  wire progress_type progress,
  input  wire logic         shared_in_use,
  input  wire logic [7:0]   host_lane_los,
  input  wire logic         auto_squelch_enable,
  output drive_type         drive,
  // State reporting
  output logic      [31:0]  path_state_register
);

  path_state_type state;
  path_state_type next_state;
  logic           teardown_request_signal;
  logic           re_teardown_request_signal;
  logic           tx_mute_request_signal;
  logic [7:0]     tx_lane_output_off;
  logic [7:0]     tx_lane_forced_mute;
  logic [7:0]     init_pending_bit;
  logic [7:0]     path_state_change_flag;
  logic [1:0]     max_init_duration_field;
  logic           significant_seen;
  logic           entering;
  logic           steady_entry;
  logic           transient_significant;
  logic           reset_teardown;

  // Host derived transition signals
  assign teardown_request_signal    = reset_teardown;
  assign re_teardown_request_signal = reset_teardown;
  assign tx_mute_request_signal     = |(tx_lane_output_off | tx_lane_forced_mute);

  // Host control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      reset_teardown          <= TEARDOWN_RESET[CTRL_TEARDOWN_BIT];
      tx_lane_output_off      <= 8'h00;
      tx_lane_forced_mute     <= 8'h00;
      max_init_duration_field <= DURATION_RESET;
    end else if (wr) begin
      unique case (addr)
        ADDR_CONTROL:  reset_teardown <= wdata[CTRL_TEARDOWN_BIT];
        ADDR_OFF:      tx_lane_output_off <= wdata[7:0];
        ADDR_MUTE:     tx_lane_forced_mute <= wdata[7:0];
        ADDR_DURATION: max_init_duration_field <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      path_ground_state:
        if (!teardown_request_signal) next_state = path_initializing_state;
      path_initializing_state:
        if (teardown_request_signal) next_state = path_teardown_state;
        else if (progress.init_done) next_state = path_ready_idle_state;
      path_ready_idle_state:
        if (re_teardown_request_signal) next_state = path_teardown_state;
        else if (!tx_mute_request_signal) next_state = tx_unmuting_state;
      path_teardown_state:
        if (progress.teardown_done && progress.tx_quiet) next_state = path_ground_state;
      tx_unmuting_state:
        if (tx_mute_request_signal) next_state = tx_muting_state;
        else if (progress.tx_stable) next_state = path_operational_state;
      path_operational_state:
        if (tx_mute_request_signal) next_state = tx_muting_state;
      tx_muting_state:
        if (progress.tx_quiet) next_state = path_ready_idle_state;
      default: next_state = path_ground_state;
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (reset) state <= path_ground_state;
    else state <= next_state;
  end

  assign entering = (next_state != state);
  // Steady entry with no exit condition already met
  assign steady_entry =
    (next_state == path_ready_idle_state && !re_teardown_request_signal
      && tx_mute_request_signal) ||
    (next_state == path_operational_state && !tx_mute_request_signal) ||
    (next_state == path_ground_state && teardown_request_signal);
  assign transient_significant =
    (state == path_initializing_state) ? max_init_duration_field[DUR_INIT_BIT]
                                       : max_init_duration_field[DUR_OTHER_BIT];

  // Tracks significant transient since last indication
  always_ff @(posedge mclk) begin
    if (reset) significant_seen <= 1'b0;
    else if (entering && steady_entry) significant_seen <= 1'b0;
    else if (entering && state != path_ready_idle_state && state != path_ground_state
             && state != path_operational_state && transient_significant)
      significant_seen <= 1'b1;
  end

  // State-changed flags, sticky; cleared only by host write
  always_ff @(posedge mclk) begin
    if (reset) path_state_change_flag <= 8'h00;
    else if (entering && steady_entry && (significant_seen || transient_significant))
      path_state_change_flag <= 8'hFF;
    else if (wr && addr == ADDR_FLAGS) path_state_change_flag <= path_state_change_flag & ~wdata[7:0];
  end

  // Pending bits cleared in initializing, set by host
  always_ff @(posedge mclk) begin
    if (reset) init_pending_bit <= PENDING_RESET;
    else if (state == path_initializing_state) init_pending_bit <= 8'h00;
    else if (wr && addr == ADDR_PENDING) init_pending_bit <= init_pending_bit | wdata[7:0];
  end

  // Per-lane state replicated on entry
  always_ff @(posedge mclk) begin
    if (reset) path_state_register <= {LANES{CODE_GROUND}};
    else if (entering) path_state_register <= {LANES{state_code(next_state)}};
  end

  // Electronics control and output quiescence
  always_ff @(posedge mclk) begin
    if (reset) begin
      drive <= '{power_on: 1'b0, configure: 1'b0, adapt_auto: 1'b0, tx_quiescent: 8'hFF};
    end else begin
      drive.configure  <= (next_state == path_initializing_state);
      drive.adapt_auto <= (next_state != path_ground_state);
      if (next_state == path_initializing_state)
        drive.power_on <= 1'b1;
      else if (next_state == path_teardown_state || next_state == path_ground_state)
        drive.power_on <= shared_in_use;
      unique case (next_state)
        path_ground_state, path_initializing_state, path_teardown_state:
          drive.tx_quiescent <= 8'hFF;
        path_ready_idle_state, tx_muting_state:
          drive.tx_quiescent <= tx_lane_output_off | tx_lane_forced_mute
            | (auto_squelch_enable ? host_lane_los : 8'h00);
        tx_unmuting_state, path_operational_state:
          drive.tx_quiescent <= auto_squelch_enable ? host_lane_los : 8'h00;
        default: drive.tx_quiescent <= 8'hFF;
      endcase
    end
  end

  // Register read, data one cycle later
  always_ff @(posedge mclk) begin
    if (reset) rdata <= 32'h0;
    else if (rd) begin
      unique case (addr)
        ADDR_CONTROL:  rdata <= {31'h0, reset_teardown};
        ADDR_OFF:      rdata <= {24'h0, tx_lane_output_off};
        ADDR_MUTE:     rdata <= {24'h0, tx_lane_forced_mute};
        ADDR_STATE:    rdata <= path_state_register;
        ADDR_FLAGS:    rdata <= {24'h0, path_state_change_flag};
        ADDR_PENDING:  rdata <= {24'h0, init_pending_bit};
        ADDR_DURATION: rdata <= {30'h0, max_init_duration_field};
        default:       rdata <= 32'h0;
      endcase
    end else rdata <= 32'h0;
  end

  // Checks
  AST_TEARDOWN_IN_INIT: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && teardown_request_signal |=> state == path_teardown_state)
    else $error("init did not go to teardown");
  AST_QUIET_IN_INIT: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && $past(state) == path_initializing_state
      |-> drive.tx_quiescent == 8'hFF)
    else $error("Tx not quiescent in init");
  AST_PENDING_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state |=> init_pending_bit == 8'h00)
    else $error("pending bits not cleared");
  AST_RETEARDOWN_PRIO: assert property (@(posedge mclk) disable iff (reset)
    state == path_ready_idle_state && re_teardown_request_signal |=> state == path_teardown_state)
    else $error("ready idle missed teardown");
  AST_IDLE_UNMUTE: assert property (@(posedge mclk) disable iff (reset)
    state == path_ready_idle_state && !re_teardown_request_signal && !tx_mute_request_signal
      |=> state == tx_unmuting_state)
    else $error("ready idle missed unmute");
  AST_UNMUTE_ABORT: assert property (@(posedge mclk) disable iff (reset)
    state == tx_unmuting_state && tx_mute_request_signal |=> state == tx_muting_state)
    else $error("unmuting missed mute request");
  AST_OPER_MUTE: assert property (@(posedge mclk) disable iff (reset)
    state == path_operational_state && tx_mute_request_signal |=> state == tx_muting_state)
    else $error("operational missed mute request");
  AST_STATE_REPORT: assert property (@(posedge mclk) disable iff (reset)
    state != $past(state) |-> path_state_register == {LANES{state_code(state)}})
    else $error("state register not updated");
  AST_FLAG_KEEP: assert property (@(posedge mclk) disable iff (reset)
    !(wr && addr == ADDR_FLAGS) |=> (path_state_change_flag & $past(path_state_change_flag))
      == $past(path_state_change_flag))
    else $error("flag cleared by state change");
  AST_TEARDOWN_DONE: assert property (@(posedge mclk) disable iff (reset)
    state == path_teardown_state && progress.teardown_done && progress.tx_quiet
      |=> state == path_ground_state)
    else $error("teardown did not finish");

  // Electronics powered and configured throughout init
  AST_POWER_IN_INIT: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state |-> drive.power_on && drive.configure)
    else $error("init without power or configure");

  // Automatic adaptation armed outside ground state
  AST_ADAPT_ARMED: assert property (@(posedge mclk) disable iff (reset)
    state != path_ground_state |-> drive.adapt_auto)
    else $error("adaptation not armed");

  // Pending bits stay clear while init lasts
  AST_PENDING_HOLD: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && $past(state) == path_initializing_state
      |-> init_pending_bit == 8'h00)
    else $error("pending bit set during init");

  // Lane controls have no effect from init entry on
  AST_CTRL_IGNORED_INIT: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state |-> drive.tx_quiescent == 8'hFF)
    else $error("lane controls acted during init");

  // No teardown from init without request
  AST_INIT_NO_TEARDOWN: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && !teardown_request_signal
      |=> state != path_teardown_state)
    else $error("init tore down unasked");

  // Init completes once electronics report ready
  AST_INIT_DONE: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && !teardown_request_signal && progress.init_done
      |=> state == path_ready_idle_state)
    else $error("init did not complete");

  // Init never completes before electronics ready
  AST_INIT_WAITS: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && !progress.init_done
      |=> state != path_ready_idle_state)
    else $error("init left early");

  // Flag set on significant steady entry into idle
  AST_FLAG_ON_ENTRY: assert property (@(posedge mclk) disable iff (reset)
    state == path_initializing_state && !teardown_request_signal && progress.init_done
      && tx_mute_request_signal && max_init_duration_field[DUR_INIT_BIT]
      |=> path_state_change_flag == 8'hFF)
    else $error("flag not set on idle entry");

  // State register only moves with the state
  AST_STATE_STEADY: assert property (@(posedge mclk) disable iff (reset)
    state == $past(state) |-> path_state_register == $past(path_state_register))
    else $error("state register moved without entry");

  // Idle lanes honour off and mute controls
  AST_IDLE_LANES: assert property (@(posedge mclk) disable iff (reset)
    state == path_ready_idle_state && $past(state) == path_ready_idle_state
      |-> (drive.tx_quiescent & $past(tx_lane_output_off | tx_lane_forced_mute))
        == $past(tx_lane_output_off | tx_lane_forced_mute))
    else $error("idle lane not quiescent");

  // Idle stays while mute request holds
  AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (reset)
    state == path_ready_idle_state && !re_teardown_request_signal && tx_mute_request_signal
      |=> state == path_ready_idle_state)
    else $error("idle left while muted");

  // Shared electronics stay powered in teardown
  AST_SHARED_POWER: assert property (@(posedge mclk) disable iff (reset)
    state == path_teardown_state && shared_in_use |=> drive.power_on)
    else $error("shared electronics powered down");

  // Teardown outputs quiescent, controls ignored
  AST_QUIET_TEARDOWN: assert property (@(posedge mclk) disable iff (reset)
    state == path_teardown_state |-> drive.tx_quiescent == 8'hFF)
    else $error("Tx not quiescent in teardown");

  // Ground state outputs quiescent
  AST_QUIET_GROUND: assert property (@(posedge mclk) disable iff (reset)
    state == path_ground_state |-> drive.tx_quiescent == 8'hFF)
    else $error("Tx not quiescent in ground");

  // Teardown waits for electronics
  AST_TEARDOWN_WAITS: assert property (@(posedge mclk) disable iff (reset)
    state == path_teardown_state && !progress.teardown_done
      |=> state == path_teardown_state)
    else $error("teardown left early");

  // Unmuting drives all lanes live when auto-squelch is off
  AST_UNMUTE_LANES: assert property (@(posedge mclk) disable iff (reset)
    state == tx_unmuting_state && $past(state) == tx_unmuting_state
      && !$past(auto_squelch_enable) |-> drive.tx_quiescent == 8'h00)
    else $error("lane muted while unmuting");

  // Unmuting ends on stable outputs
  AST_UNMUTE_DONE: assert property (@(posedge mclk) disable iff (reset)
    state == tx_unmuting_state && !tx_mute_request_signal && progress.tx_stable
      |=> state == path_operational_state)
    else $error("unmuting did not finish");

  // Unmuting waits for stable outputs
  AST_UNMUTE_WAITS: assert property (@(posedge mclk) disable iff (reset)
    state == tx_unmuting_state && !progress.tx_stable
      |=> state != path_operational_state)
    else $error("operational before outputs stable");

  // Operational lanes live unless squelched
  AST_OPER_LIVE: assert property (@(posedge mclk) disable iff (reset)
    state == path_operational_state && $past(state) == path_operational_state
      |-> (drive.tx_quiescent & ~$past(host_lane_los)) == 8'h00)
    else $error("operational lane muted");

  // Operational stays without mute request
  AST_OPER_HOLD: assert property (@(posedge mclk) disable iff (reset)
    state == path_operational_state && !tx_mute_request_signal
      |=> state == path_operational_state)
    else $error("operational left unasked");

  // Auto-squelch mutes lanes with lost input
  AST_SQUELCH_LANE: assert property (@(posedge mclk) disable iff (reset)
    state == path_operational_state && $past(state) == path_operational_state
      && $past(auto_squelch_enable) |-> drive.tx_quiescent == $past(host_lane_los))
    else $error("auto-squelch not applied");

  // Lane off write raises mute request
  AST_MUTE_REQ: assert property (@(posedge mclk) disable iff (reset)
    wr && addr == ADDR_OFF && wdata[7:0] != 8'h00 |=> tx_mute_request_signal)
    else $error("lane off without mute request");

  // Flags rise only on steady state entry
  AST_FLAG_ONLY_STEADY: assert property (@(posedge mclk) disable iff (reset)
    (path_state_change_flag & ~$past(path_state_change_flag)) != 8'h00
      |-> state == path_ready_idle_state || state == path_operational_state
        || state == path_ground_state)
    else $error("flag raised outside steady entry");

  // Every lane reports the same state code
  AST_ONE_MACHINE: assert property (@(posedge mclk) disable iff (reset)
    path_state_register == {LANES{path_state_register[3:0]}})
    else $error("lanes report different states");

endmodule // data_path_state_machine
`default_nettype wire

// ===== testbench/path_electronics_model.sv
`default_nettype none
module path_electronics_model
  import path_sm_pkg::*;
(
  // Clock
  input  wire logic      mclk,
  // Controls from the block
  input  wire drive_type drive,
  input  wire logic      stall,
  // Progress back to the block
  output progress_type   progress
);
  timeunit 1ns;
  timeprecision 1ns;
  // Electronics answer one cycle late; stall holds off completion except Tx quiet
  always_ff @(posedge mclk) begin
    progress.init_done     <= drive.power_on & drive.configure & !stall;
    progress.teardown_done <= !stall;
    progress.tx_stable     <= (drive.tx_quiescent == 8'h00) & !stall;
    progress.tx_quiet      <= (drive.tx_quiescent != 8'h00);
  end
endmodule // path_electronics_model
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
module tb_top
  import path_sm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  logic [3:0]   addr = 4'h0;
  logic [31:0]  wdata = 32'h0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [31:0]  rdata;
  progress_type progress;
  logic         shared_in_use = 1'b0;
  logic [7:0]   host_lane_los = 8'h00;
  logic         auto_squelch_enable = 1'b0;
  drive_type    drive;
  logic [31:0]  path_state_register;
  logic         stall = 1'b0;
  int           miscompares = 0;
  int           checked = 0;
  logic [31:0]  rv;
  // 20 MHz clock
  always #25 mclk = ~mclk;
  data_path_state_machine i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .progress(progress), .shared_in_use(shared_in_use),
    .host_lane_los(host_lane_los), .auto_squelch_enable(auto_squelch_enable),
    .drive(drive), .path_state_register(path_state_register));
  path_electronics_model i_elec (.mclk(mclk), .drive(drive), .stall(stall),
    .progress(progress));
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register bus cycles
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait for a state code, then check all lanes
  task automatic wait_code(input logic [3:0] c);
    int n;
    n = 0;
    while (path_state_register[3:0] !== c && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    check("state", path_state_register, {8{c}});
  endtask
  // Reset values
  task automatic test_reset();
    #1 check("state", path_state_register, {8{CODE_GROUND}});
    check("quiet", drive.tx_quiescent, 8'hFF);
    check("power", drive.power_on, 1'b0);
    rd_reg(ADDR_PENDING, rv);
    check("pending", rv, PENDING_RESET);
    rd_reg(ADDR_DURATION, rv);
    check("duration", rv, DURATION_RESET);
    rd_reg(ADDR_CONTROL, rv);
    check("control", rv[0], TEARDOWN_RESET[0]);
  endtask
  // Init with stalled electronics, controls ignored, then abort to teardown
  task automatic test_init_abort();
    stall <= 1'b1;
    shared_in_use <= 1'b1;
    wr_reg(ADDR_CONTROL, 32'h0);
    wait_code(CODE_INITIALIZING);
    check("power", {drive.power_on, drive.configure}, 2'b11);
    check("adapt", drive.adapt_auto, 1'b1);
    wr_reg(ADDR_OFF, 32'h0);
    wr_reg(ADDR_MUTE, 32'h0);
    #1 check("quiet", drive.tx_quiescent, 8'hFF);
    rd_reg(ADDR_PENDING, rv);
    check("pending", rv[7:0], 8'h00);
    wr_reg(ADDR_CONTROL, 32'h1);
    wait_code(CODE_TEARDOWN);
    check("shared power", drive.power_on, 1'b1);
    wr_reg(ADDR_MUTE, 32'h0);
    repeat (3) @(posedge mclk);
    #1 check("quiet", drive.tx_quiescent, 8'hFF);
    stall <= 1'b0;
    wait_code(CODE_GROUND);
  endtask
  // Bring-up through idle, unmuting and operational
  task automatic test_bringup();
    wr_reg(ADDR_OFF, 32'h05);
    wr_reg(ADDR_CONTROL, 32'h0);
    wait_code(CODE_READY_IDLE);
    repeat (3) @(posedge mclk);
    #1 check("idle quiet", drive.tx_quiescent, 8'h05);
    rd_reg(ADDR_FLAGS, rv);
    check("flag", rv != 32'h0, 1'b1);
    stall <= 1'b1;
    wr_reg(ADDR_OFF, 32'h0);
    wait_code(CODE_UNMUTING);
    #1 check("unmuted", drive.tx_quiescent, 8'h00);
    wr_reg(ADDR_MUTE, 32'h80);
    wait_code(CODE_MUTING);
    wait_code(CODE_READY_IDLE);
    stall <= 1'b0;
    wr_reg(ADDR_MUTE, 32'h0);
    wait_code(CODE_OPERATIONAL);
    #1 check("live", drive.tx_quiescent, 8'h00);
    auto_squelch_enable <= 1'b1;
    host_lane_los <= 8'h02;
    repeat (3) @(posedge mclk);
    #1 check("squelch", drive.tx_quiescent[1], 1'b1);
    auto_squelch_enable <= 1'b0;
    host_lane_los <= 8'h00;
  endtask
  // Mute from operational, flags kept, re-teardown from idle
  task automatic test_mute_teardown();
    wr_reg(ADDR_FLAGS, 32'hFF);
    rd_reg(ADDR_FLAGS, rv);
    check("flag clear", rv, 32'h0);
    wr_reg(ADDR_OFF, 32'h40);
    wait_code(CODE_MUTING);
    wait_code(CODE_READY_IDLE);
    rd_reg(ADDR_FLAGS, rv);
    check("flag set", rv != 32'h0, 1'b1);
    stall <= 1'b1;
    wr_reg(ADDR_CONTROL, 32'h1);
    wait_code(CODE_TEARDOWN);
    rd_reg(ADDR_FLAGS, rv);
    check("flag kept", rv != 32'h0, 1'b1);
    stall <= 1'b0;
    wait_code(CODE_GROUND);
    rd_reg(4'hF, rv);
    check("unmapped", rv, 32'h0);
  endtask
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    test_reset();
    test_init_abort();
    test_bringup();
    test_mute_teardown();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
